// *** bench/tturb_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tturb_consts.vh"
module tturb_props #(
	parameter W = 32
) (
	// Clock and reset.
	input wire logic         sys_clk,
	input wire logic         resetn,
	// Register port.
	input wire logic [15:0]  reg_addr,
	input wire logic [31:0]  reg_wdata,
	input wire logic         reg_wr,
	input wire logic         reg_rd,
	input wire logic [31:0]  reg_rdata_reg,
	// Engine pins and data path.
	input wire logic         connection_on,
	input wire logic         timeout_interrupt,
	input wire logic         word_ready,
	input wire logic         check_valid,
	input wire logic [W-1:0] check_data,
	input wire logic         word_valid_reg,
	input wire logic [W-1:0] word_data_reg,
	input wire logic         irq_reg
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic [31:0] len_q;
	wire w_cmd = reg_wr && reg_addr == `TTURB_ADDR_CMD;
	wire w_rst = reg_wr && reg_addr == `TTURB_ADDR_RST;
	wire r_cmd = reg_rd && reg_addr == `TTURB_ADDR_CMD;
	wire r_rst = reg_rd && reg_addr == `TTURB_ADDR_RST;
	wire r_len = reg_rd && reg_addr == `TTURB_ADDR_TXLEN;
	// Last length written, to know if a start runs.
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			len_q <= 32'h0;
		else if (reg_wr && reg_addr == `TTURB_ADDR_TXLEN)
			len_q <= reg_wdata;
	end
	sequence s_go;
		w_cmd && !reg_wdata[0] && len_q != 0 ##1 r_cmd;
	endsequence
	sequence s_eclr;
		!check_valid[*3] ##0 w_cmd ##1 r_cmd && !check_valid;
	endsequence
	sequence s_tclr;
		!timeout_interrupt[*4] ##0 w_rst && reg_wdata[8] ##1 r_rst;
	endsequence
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_reg == 0)
		else $error("read data not zero outside read");
	AST_LEN_CLR: assert property (w_cmd ##1 r_len |=> reg_rdata_reg == 0)
		else $error("count not cleared by command write");
	AST_BUSY: assert property (s_go |=> reg_rdata_reg[0])
		else $error("busy not shown after start");
	AST_ERR_CLR: assert property (s_eclr |=> !reg_rdata_reg[1])
		else $error("error flag not cleared by command");
	AST_CONN: assert property ($stable(connection_on)[*5] ##0 r_cmd
		|=> reg_rdata_reg[2] == $past(connection_on))
		else $error("connection bit wrong");
	AST_RST_SELF: assert property (r_rst |=> !reg_rdata_reg[0])
		else $error("reset bit not self cleared");
	AST_TSET: assert property (timeout_interrupt[*6] ##0 r_rst
		|=> reg_rdata_reg[8])
		else $error("timer latch not set");
	AST_TCLR: assert property (s_tclr |=> !reg_rdata_reg[8])
		else $error("timer latch not cleared");
endmodule // tturb_props
bind tturb_user_regs tturb_props #(.W(W)) u_props (.sys_clk(sys_clk),
	.resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg),
	.connection_on(connection_on), .timeout_interrupt(timeout_interrupt),
	.word_ready(word_ready), .check_valid(check_valid),
	.check_data(check_data), .word_valid_reg(word_valid_reg),
	.word_data_reg(word_data_reg), .irq_reg(irq_reg));
`default_nettype wire

// *** bench/tturb_user_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tturb_consts.vh"
module tturb_user_regs_tb;
	logic        sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
	logic        connection_on = 0, timeout_interrupt = 0, corrupt = 0;
	logic        word_ready = 0, check_valid = 0;
	logic [15:0] reg_addr = 16'h0;
	logic [31:0] reg_wdata = 0, check_data = 0, d, v, vr, n, exp_w = 0;
	logic [31:0] seed = 32'h3B;
	wire  [31:0] reg_rdata_reg, word_data_reg;
	wire         word_valid_reg, irq_reg;
	int          fail_count = 0, compares = 0, cyc = 0, i, k;
	tturb_user_regs #(.W(32)) DUT (.sys_clk(sys_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg),
		.connection_on(connection_on), .timeout_interrupt(timeout_interrupt),
		.word_ready(word_ready), .check_valid(check_valid),
		.check_data(check_data), .word_valid_reg(word_valid_reg),
		.word_data_reg(word_data_reg), .irq_reg(irq_reg));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task close_out;
		if (fail_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string s, input [31:0] e, input [31:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task wr(input [15:0] a, input [31:0] x);
		@(posedge sys_clk);
		reg_rd <= 0; reg_wr <= 1; reg_addr <= a; reg_wdata <= x;
	endtask
	task rd(input [15:0] a);
		@(posedge sys_clk);
		reg_wr <= 0; reg_rd <= 1; reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 0;
		#1 d = reg_rdata_reg;
	endtask
	task idle(input int c);
		repeat (c) @(posedge sys_clk) reg_wr <= 0;
	endtask
	// Random sink stall, loopback of words, pattern check.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			close_out;
		end
		vr = xs();
		word_ready <= vr[0];
		check_valid <= word_valid_reg & word_ready;
		check_data <= word_data_reg ^ {31'h0, corrupt};
		if (word_valid_reg && word_ready) begin
			chk("word", exp_w, word_data_reg);
			exp_w = exp_w + 1;
		end
	end
	task run(input [31:0] c, input e, input q);
		wr(`TTURB_ADDR_TXLEN, n);
		exp_w = 0;
		wr(`TTURB_ADDR_CMD, c);
		rd(`TTURB_ADDR_CMD); chk("busy", 1, d[0]);
		for (k = 0; d[0] && k < 100; k++) rd(`TTURB_ADDR_CMD);
		chk("idle", 0, d[0]);
		rd(`TTURB_ADDR_TXLEN); chk("count", n, d);
		chk("words", n, exp_w);
		rd(`TTURB_ADDR_CMD); chk("err", e, d[1]);
		rd(`TTURB_ADDR_IRQ_STAT); chk("done", 1, d[0]);
		chk("irq", q, irq_reg);
		wr(`TTURB_ADDR_IRQ_CLR, 7); idle(2); chk("irq clr", 0, irq_reg);
	endtask
	initial begin
		repeat (8) @(posedge sys_clk); resetn <= 1;
		rd(16'h1020); chk("unmapped", 0, d);
		rd(`TTURB_ADDR_RST); chk("timer", 0, d[8]);
		wr(`TTURB_ADDR_IRQ_EN, 1);
		for (i = 0; i < 6; i++) begin
			n = i ? xs() % 8 + 1 : 1;
			corrupt = i > 2;
			if (i == 5) wr(`TTURB_ADDR_IRQ_EN, 0);
			run(i == 4 ? 0 : 2, i != 4 && i > 2, i != 5);
		end
		wr(`TTURB_ADDR_TXLEN, 40); exp_w = 0; wr(`TTURB_ADDR_CMD, 0);
		wr(`TTURB_ADDR_CMD, 1); rd(`TTURB_ADDR_TXLEN);
		chk("abort", 0, d);
		exp_w = 0; wr(`TTURB_ADDR_CMD, 2); idle(6);
		wr(`TTURB_ADDR_RST, 1); idle(2); rd(`TTURB_ADDR_CMD);
		chk("soft busy", 0, d[0]);
		chk("soft err", 0, d[1]);
		rd(`TTURB_ADDR_RST); chk("rst bit", 0, d[0]);
		@(posedge sys_clk) timeout_interrupt <= 1;
		idle(6); rd(`TTURB_ADDR_RST); chk("tset", 1, d[8]);
		timeout_interrupt <= 0;
		idle(4); rd(`TTURB_ADDR_RST); chk("thold", 1, d[8]);
		rd(`TTURB_ADDR_IRQ_STAT); chk("tstat", 1, d[2]);
		wr(`TTURB_ADDR_RST, 32'h100); rd(`TTURB_ADDR_RST);
		chk("tclr", 0, d[8]);
		for (i = 0; i < 4; i++) begin
			@(posedge sys_clk) connection_on <= ~connection_on;
			idle(5); rd(`TTURB_ADDR_CMD); chk("conn", connection_on, d[2]);
		end
		close_out;
	end
endmodule // tturb_user_regs_tb
`default_nettype wire

// *** design/tturb_consts.vh ***
`ifndef TTURB_CONSTS_VH
`define TTURB_CONSTS_VH
// Register byte addresses.
`define TTURB_ADDR_TXLEN      16'h1000
`define TTURB_ADDR_CMD        16'h1004
`define TTURB_ADDR_RST        16'h1008
`define TTURB_ADDR_IRQ_STAT   16'h1010
`define TTURB_ADDR_IRQ_EN     16'h1014
`define TTURB_ADDR_IRQ_CLR    16'h1018
// Command register fields.
`define TTURB_CMD_START_BIT   0
`define TTURB_CMD_VERIFY_BIT  1
`define TTURB_CMD_BUSY_BIT    0
`define TTURB_CMD_ERR_BIT     1
`define TTURB_CMD_CONN_BIT    2
// Reset register fields.
`define TTURB_RST_LOGIC_BIT   0
`define TTURB_RST_TIMER_BIT   8
// Interrupt status fields.
`define TTURB_IRQ_DONE_BIT    0
`define TTURB_IRQ_ERR_BIT     1
`define TTURB_IRQ_TIMER_BIT   2
`define TTURB_IRQ_W           3
// Reset values and the increment constant.
`define TTURB_ZERO32          32'h00000000
`define TTURB_ONE32           32'h00000001
`define TTURB_IRQ_ZERO        3'h0
`endif

// *** design/tturb_pattern_generator.v ***
`timescale 1ns/1ps
`default_nettype none
`include "tturb_consts.vh"

module tturb_pattern_generator #(
	parameter W = 32
) (
	// Clock and reset.
	input  wire         sys_clk,
	input  wire         resetn,
	// Control.
	input  wire         start,
	input  wire         verify_en,
	input  wire [W-1:0] total_len,
	// Sink flow control and loopback check data.
	input  wire         word_ready,
	input  wire         check_valid,
	input  wire [W-1:0] check_data,
	// Status and word output.
	output reg          busy_reg,
	output reg  [W-1:0] sent_reg,
	output reg          err_reg,
	output reg          word_valid_reg,
	output reg  [W-1:0] word_data_reg
);
	localparam [W-1:0] ONE = `TTURB_ONE32;
	reg [W-1:0] exp_reg;
	reg         ven_reg;
	wire        take = busy_reg & word_valid_reg & word_ready;

	always @(posedge sys_clk) begin
		if (!resetn || start) begin
			sent_reg       <= {W{1'b0}};
			err_reg        <= 1'b0;
			exp_reg        <= {W{1'b0}};
			word_data_reg  <= {W{1'b0}};
			busy_reg       <= start & resetn & (total_len != {W{1'b0}});
			word_valid_reg <= start & resetn & (total_len != {W{1'b0}});
			ven_reg        <= start & verify_en;
		end else begin
			if (take) begin
				sent_reg      <= sent_reg + ONE;
				word_data_reg <= word_data_reg + ONE;
				if (sent_reg + ONE == total_len) begin
					busy_reg       <= 1'b0;
					word_valid_reg <= 1'b0;
				end
			end
			if (check_valid && ven_reg) begin
				exp_reg <= exp_reg + ONE;
				if (check_data != exp_reg)
					err_reg <= 1'b1;
			end
		end
	end
endmodule // tturb_pattern_generator
`default_nettype wire

// *** design/tturb_user_regs.v ***
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tturb_consts.vh"

module tturb_user_regs #(
	parameter W = 32
) (
	// Clock and reset.
	input  wire         sys_clk,
	input  wire         resetn,
	// Register port.
	input  wire [15:0]  reg_addr,
	input  wire [31:0]  reg_wdata,
	input  wire         reg_wr,
	input  wire         reg_rd,
	output reg  [31:0]  reg_rdata_reg,
	// Engine status pins.
	input  wire         connection_on,
	input  wire         timeout_interrupt,
	// Pattern data path.
	input  wire         word_ready,
	input  wire         check_valid,
	input  wire [W-1:0] check_data,
	output wire         word_valid_reg,
	output wire [W-1:0] word_data_reg,
	// Interrupt.
	output reg          irq_reg
);
	// Engine pins in the order they enter the synchroniser bank.
	localparam NPIN     = 2;
	localparam PIN_CONN = 0;
	localparam PIN_TMR  = 1;

	// Pin synchronisers, one two-stage chain per engine pin.
	wire [NPIN-1:0] pin_raw;
	wire [NPIN-1:0] pin_sync;

	assign pin_raw[PIN_CONN] = connection_on;
	assign pin_raw[PIN_TMR]  = timeout_interrupt;

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
			reg [1:0] chain_reg;

			always @(posedge sys_clk) begin
				if (!resetn) begin
					chain_reg <= 2'h0;
				end else begin
					chain_reg <= {chain_reg[0], pin_raw[gi]};
				end
			end

			assign pin_sync[gi] = chain_reg[1];
		end
	endgenerate

	wire conn_sync = pin_sync[PIN_CONN];
	wire tmr_sync  = pin_sync[PIN_TMR];

	// Register decode.
	wire wr_len = reg_wr && (reg_addr == `TTURB_ADDR_TXLEN);
	wire wr_cmd = reg_wr && (reg_addr == `TTURB_ADDR_CMD);
	wire wr_rst = reg_wr && (reg_addr == `TTURB_ADDR_RST);
	wire wr_ien = reg_wr && (reg_addr == `TTURB_ADDR_IRQ_EN);
	wire wr_icl = reg_wr && (reg_addr == `TTURB_ADDR_IRQ_CLR);

	// Register state.
	reg [31:0]             len_reg;
	reg                    logic_rst_reg;
	reg                    conn_reg;
	reg                    tmr_latch_reg;
	reg                    tmr_latch_next;
	reg [`TTURB_IRQ_W-1:0] ist_reg;
	reg [`TTURB_IRQ_W-1:0] ien_reg;
	reg [`TTURB_IRQ_W-1:0] ist_next;
	reg [`TTURB_IRQ_W-1:0] ien_next;
	reg                    irq_next;
	reg                    busy_d_reg;
	reg                    err_d_reg;
	reg [31:0]             rdata_next;

	wire user_rstn = resetn & ~logic_rst_reg;
	wire start = wr_cmd & ~reg_wdata[`TTURB_CMD_START_BIT];
	wire abort = wr_cmd & reg_wdata[`TTURB_CMD_START_BIT];
	wire gen_rstn = user_rstn & ~abort;

	// Generator status.
	wire         pg_busy;
	wire         pg_err;
	wire [W-1:0] pg_sent;

	// The generator's own flip-flops drive the word outputs directly.
	tturb_pattern_generator #(.W(W)) u_gen (
		.sys_clk        (sys_clk),
		.resetn         (gen_rstn),
		.start          (start),
		.verify_en      (reg_wdata[`TTURB_CMD_VERIFY_BIT]),
		.total_len      (len_reg[W-1:0]),
		.word_ready     (word_ready),
		.check_valid    (check_valid),
		.check_data     (check_data),
		.busy_reg       (pg_busy),
		.sent_reg       (pg_sent),
		.err_reg        (pg_err),
		.word_valid_reg (word_valid_reg),
		.word_data_reg  (word_data_reg)
	);

	always @(posedge sys_clk) begin
		if (!resetn) begin
			len_reg <= `TTURB_ZERO32;
		end else if (wr_len) begin
			len_reg <= reg_wdata;
		end
	end

	always @(posedge sys_clk) begin
		if (!resetn) begin
			logic_rst_reg <= 1'b0;
		end else begin
			logic_rst_reg <= wr_rst & reg_wdata[`TTURB_RST_LOGIC_BIT];
		end
	end

	always @(posedge sys_clk) begin
		if (!resetn) begin
			conn_reg <= 1'b0;
		end else begin
			conn_reg <= conn_sync;
		end
	end

	always @* begin
		tmr_latch_next = tmr_latch_reg;
		if (wr_rst && reg_wdata[`TTURB_RST_TIMER_BIT]) begin
			tmr_latch_next = 1'b0;
		end
		if (tmr_sync) begin
			tmr_latch_next = 1'b1;
		end
	end

	always @(posedge sys_clk) begin
		if (!resetn) begin
			tmr_latch_reg <= 1'b0;
		end else begin
			tmr_latch_reg <= tmr_latch_next;
		end
	end

	// Interrupt events: done, error rise, timer; a set beats a clear.
	always @* begin
		ist_next = ist_reg;
		if (wr_icl) begin
			ist_next = ist_reg & ~reg_wdata[`TTURB_IRQ_W-1:0];
		end
		if (busy_d_reg && !pg_busy) begin
			ist_next[`TTURB_IRQ_DONE_BIT] = 1'b1;
		end
		if (pg_err && !err_d_reg) begin
			ist_next[`TTURB_IRQ_ERR_BIT] = 1'b1;
		end
		if (tmr_sync) begin
			ist_next[`TTURB_IRQ_TIMER_BIT] = 1'b1;
		end
	end

	// Enable register and the level that the output takes next.
	always @* begin
		ien_next = ien_reg;
		if (wr_ien) begin
			ien_next = reg_wdata[`TTURB_IRQ_W-1:0];
		end
		irq_next = |(ist_next & ien_next);
	end

	// Event edge detectors.
	always @(posedge sys_clk) begin
		if (!resetn) begin
			busy_d_reg <= 1'b0;
			err_d_reg  <= 1'b0;
		end else begin
			busy_d_reg <= pg_busy;
			err_d_reg  <= pg_err;
		end
	end

	// Status and enable registers.
	always @(posedge sys_clk) begin
		if (!resetn) begin
			ist_reg <= `TTURB_IRQ_ZERO;
			ien_reg <= `TTURB_IRQ_ZERO;
		end else begin
			ist_reg <= ist_next;
			ien_reg <= ien_next;
		end
	end

	// Level interrupt output.
	always @(posedge sys_clk) begin
		if (!resetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	// Read multiplexer; zero outside a read.
	always @* begin
		rdata_next = `TTURB_ZERO32;
		if (reg_rd) begin
			case (reg_addr)
			`TTURB_ADDR_TXLEN: begin
				rdata_next = pg_sent;
			end
			`TTURB_ADDR_CMD: begin
				rdata_next[`TTURB_CMD_BUSY_BIT] = pg_busy;
				rdata_next[`TTURB_CMD_ERR_BIT]  = pg_err;
				rdata_next[`TTURB_CMD_CONN_BIT] = conn_reg;
			end
			`TTURB_ADDR_RST: begin
				rdata_next[`TTURB_RST_TIMER_BIT] = tmr_latch_reg;
			end
			`TTURB_ADDR_IRQ_STAT: begin
				rdata_next[`TTURB_IRQ_W-1:0] = ist_reg;
			end
			`TTURB_ADDR_IRQ_EN: begin
				rdata_next[`TTURB_IRQ_W-1:0] = ien_reg;
			end
			default: begin
				rdata_next = `TTURB_ZERO32;
			end
			endcase
		end
	end

	// Read data, one cycle after the strobe.
	always @(posedge sys_clk) begin
		if (!resetn) begin
			reg_rdata_reg <= `TTURB_ZERO32;
		end else begin
			reg_rdata_reg <= rdata_next;
		end
	end
endmodule // tturb_user_regs
`default_nettype wire
